// file: hdl/ota_pkg.sv
// constants and helpers shared by the over-temperature alarm block
package ota_pkg;

  // command bytes of the registers held in this block
  localparam logic [7:0] OTA_CMD_COMMON = 8'h02;
  localparam logic [7:0] OTA_CMD_STAT1  = 8'h08;
  localparam logic [7:0] OTA_CMD_STAT2  = 8'h09;
  localparam logic [7:0] OTA_CMD_STAT3  = 8'h0A;
  localparam logic [7:0] OTA_CMD_MASK1  = 8'h0C;
  localparam logic [7:0] OTA_CMD_MASK2  = 8'h0D;
  localparam logic [7:0] OTA_CMD_MASK3  = 8'h0E;

  // width of every status and mask field, bit positions within it
  localparam int OTA_FIELD_W  = 3;
  localparam int OTA_BIT_LOC  = 0;
  localparam int OTA_BIT_REM1 = 1;
  localparam int OTA_BIT_REM2 = 2;

  // summary flag positions in the common status register
  localparam int OTA_SUM_FIRST  = 1;
  localparam int OTA_SUM_SECOND = 2;
  localparam int OTA_SUM_THIRD  = 3;

  // power-up values of the mask fields
  localparam logic [2:0] OTA_MASK1_RST = 3'h1;
  localparam logic [2:0] OTA_MASK2_RST = 3'h0;
  localparam logic [2:0] OTA_MASK3_RST = 3'h7;

  // power-up value of a status flag
  localparam logic OTA_FLAG_RST = 1'b0;

  // comparator slots: one local, two per remote channel
  localparam int OTA_CMP_LOC  = 0;
  localparam int OTA_CMP_R1L1 = 1;
  localparam int OTA_CMP_R2L1 = 2;
  localparam int OTA_CMP_R1L2 = 3;
  localparam int OTA_CMP_R2L2 = 4;
  localparam int OTA_NUM_CMP  = 5;

  // reading has reached its limit
  function automatic logic ota_at_limit(input logic [7:0] reading,
                                        input logic [7:0] limit);
    return reading >= limit;
  endfunction

  // reading is below limit minus hysteresis, without underflow
  function automatic logic ota_below_band(input logic [7:0] reading,
                                          input logic [7:0] limit,
                                          input logic [7:0] hyst);
    logic [8:0] sum;
    sum = {1'b0, reading} + {1'b0, hyst};
    return sum < {1'b0, limit};
  endfunction

endpackage

// file: hdl/ota_hyst_compare.sv
// one hysteretic limit comparator producing a status flag
`timescale 1ns/1ps
module ota_hyst_compare (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [7:0] reading,
  input  wire logic [7:0] limit,
  input  wire logic [7:0] hyst,
  output logic            flagQ
);

  logic flagD;

  // set at the limit, clear below the band, otherwise hold
  always_comb begin
    flagD = flagQ; // inside the band the flag keeps its value
    if (ota_pkg::ota_at_limit(reading, limit)) begin
      flagD = 1'b1;
    end else if (ota_pkg::ota_below_band(reading, limit, hyst)) begin
      flagD = 1'b0;
    end
  end

  // flag register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flagQ <= ota_pkg::OTA_FLAG_RST;
    end else begin
      flagQ <= flagD;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // a reading inside the band leaves the flag untouched
  band_hold_a: assert property (
    (!ota_pkg::ota_at_limit(reading, limit) &&
     !ota_pkg::ota_below_band(reading, limit, hyst)) |=> $stable(flagQ))
    else $error("flag moved while reading inside hysteresis band");

  band_hold_c: cover property (
    flagQ && !ota_pkg::ota_at_limit(reading, limit) &&
    !ota_pkg::ota_below_band(reading, limit, hyst) ##1 flagQ);

endmodule // ota_hyst_compare

// file: hdl/ota_alarm_status_mask.sv
// over-temperature alarm status, masks and alarm outputs
`timescale 1ns/1ps
// Overview of operation
// - first output active on any unmasked status bit
// - first output released when status all zero
// - second output follows its unmasked status bits
// - third output follows its unmasked status bits
// - remote two first-level flag with hysteresis
// - remote one first-level flag with hysteresis
// - local flag in all three statuses
// - remote two second-level flag, shared by two
// - remote one second-level flag, shared by two
// - status registers read-only, upper bits zero
// - mask bit one blocks that event
// - first mask at 0x0C, powers up 0x01
// - common status summarises each alarm status
// - third output has its own mask register
module ota_alarm_status_mask (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [7:0] localTemp,
  input  wire logic [7:0] remoteOneTemp,
  input  wire logic [7:0] remoteTwoTemp,
  input  wire logic [7:0] localLimit,
  input  wire logic [7:0] remoteOneLimitFirst,
  input  wire logic [7:0] remoteTwoLimitFirst,
  input  wire logic [7:0] remoteOneLimitSecond,
  input  wire logic [7:0] remoteTwoLimitSecond,
  input  wire logic [7:0] commonHyst,
  input  wire logic [7:0] cmdAddr,
  input  wire logic       cmdWrEn,
  input  wire logic [7:0] cmdWrData,
  input  wire logic       cmdRdEn,
  output logic      [7:0] cmdRdData,
  output logic            cmdRdValid,
  output logic            overtempOutFirstN,
  output logic            overtempOutSecondN,
  output logic            overtempOutThirdN
);

  localparam int W = ota_pkg::OTA_FIELD_W;

  logic [7:0]   cmpReading [ota_pkg::OTA_NUM_CMP];
  logic [7:0]   cmpLimit   [ota_pkg::OTA_NUM_CMP];
  logic [ota_pkg::OTA_NUM_CMP-1:0] cmpFlag;
  logic         localFlagFirstOut;
  logic         remoteOneLevelOneFlag;
  logic         remoteTwoLevelOneFlag;
  logic         localFlagSecondOut;
  logic         remoteOneLevelTwoFlag;
  logic         remoteTwoLevelTwoFlag;
  logic         localFlagThirdOut;
  logic         remoteOneThirdOutFlag;
  logic         remoteTwoThirdOutFlag;
  logic [W-1:0] statFirst;
  logic [W-1:0] statSecond;
  logic [W-1:0] statThird;
  logic         thirdAlarmSummaryFlag;
  logic [7:0]   commonStatus;
  logic [W-1:0] mask1Q;
  logic [W-1:0] mask1D;
  logic [W-1:0] mask2Q;
  logic [W-1:0] mask2D;
  logic [W-1:0] mask3Q;
  logic [W-1:0] mask3D;
  logic         remoteTwoFirstOutBlock;
  logic         remoteOneFirstOutBlock;
  logic         localEventBlock;
  logic [2:0]   alarmNQ;
  logic [2:0]   alarmND;
  logic [7:0]   rdDataQ;
  logic [7:0]   rdDataD;
  logic         rdValidQ;
  logic [7:0]   rdAddrQ;

  // widen a 3-bit field to a byte, upper bits reading as zero
  function automatic logic [7:0] ota_pad(input logic [W-1:0] f);
    return {5'h00, f};
  endfunction

  // comparator inputs: local shared, remote limits per level
  always_comb begin
    cmpReading[ota_pkg::OTA_CMP_LOC]  = localTemp;
    cmpLimit[ota_pkg::OTA_CMP_LOC]    = localLimit;
    cmpReading[ota_pkg::OTA_CMP_R1L1] = remoteOneTemp;
    cmpLimit[ota_pkg::OTA_CMP_R1L1]   = remoteOneLimitFirst;
    cmpReading[ota_pkg::OTA_CMP_R2L1] = remoteTwoTemp;
    cmpLimit[ota_pkg::OTA_CMP_R2L1]   = remoteTwoLimitFirst;
    cmpReading[ota_pkg::OTA_CMP_R1L2] = remoteOneTemp;
    cmpLimit[ota_pkg::OTA_CMP_R1L2]   = remoteOneLimitSecond;
    cmpReading[ota_pkg::OTA_CMP_R2L2] = remoteTwoTemp;
    cmpLimit[ota_pkg::OTA_CMP_R2L2]   = remoteTwoLimitSecond;
  end

  // one hysteretic comparator per distinct reading and limit pair
  for (genvar i = 0; i < ota_pkg::OTA_NUM_CMP; i++) begin : g_cmp
    ota_hyst_compare u_cmp (
      .core_clk (core_clk),
      .rstn     (rstn),
      .reading  (cmpReading[i]),
      .limit    (cmpLimit[i]),
      .hyst     (commonHyst),
      .flagQ    (cmpFlag[i])
    );
  end

  // status fields; second and third share the second-level limits
  assign localFlagFirstOut     = cmpFlag[ota_pkg::OTA_CMP_LOC];
  assign localFlagSecondOut    = cmpFlag[ota_pkg::OTA_CMP_LOC];
  assign localFlagThirdOut     = cmpFlag[ota_pkg::OTA_CMP_LOC];
  assign remoteOneLevelOneFlag = cmpFlag[ota_pkg::OTA_CMP_R1L1];
  assign remoteTwoLevelOneFlag = cmpFlag[ota_pkg::OTA_CMP_R2L1];
  assign remoteOneLevelTwoFlag = cmpFlag[ota_pkg::OTA_CMP_R1L2];
  assign remoteOneThirdOutFlag = cmpFlag[ota_pkg::OTA_CMP_R1L2];
  assign remoteTwoLevelTwoFlag = cmpFlag[ota_pkg::OTA_CMP_R2L2];
  assign remoteTwoThirdOutFlag = cmpFlag[ota_pkg::OTA_CMP_R2L2];
  assign statFirst  = {remoteTwoLevelOneFlag, remoteOneLevelOneFlag,
                       localFlagFirstOut};
  assign statSecond = {remoteTwoLevelTwoFlag, remoteOneLevelTwoFlag,
                       localFlagSecondOut};
  assign statThird  = {remoteTwoThirdOutFlag, remoteOneThirdOutFlag,
                       localFlagThirdOut};

  // summary flags of the common status register
  assign thirdAlarmSummaryFlag = |statThird;
  always_comb begin
    commonStatus = 8'h00;
    commonStatus[ota_pkg::OTA_SUM_FIRST]  = |statFirst;
    commonStatus[ota_pkg::OTA_SUM_SECOND] = |statSecond;
    commonStatus[ota_pkg::OTA_SUM_THIRD]  = thirdAlarmSummaryFlag;
  end

  // mask block bits of the first output
  assign remoteTwoFirstOutBlock = mask1Q[ota_pkg::OTA_BIT_REM2];
  assign remoteOneFirstOutBlock = mask1Q[ota_pkg::OTA_BIT_REM1];
  assign localEventBlock        = mask1Q[ota_pkg::OTA_BIT_LOC];

  // mask writes and active-low alarm outputs, next values
  always_comb begin
    mask1D = mask1Q;
    mask2D = mask2Q;
    mask3D = mask3Q;
    if (cmdWrEn) begin
      unique case (cmdAddr)
        ota_pkg::OTA_CMD_MASK1: mask1D = cmdWrData[W-1:0];
        ota_pkg::OTA_CMD_MASK2: mask2D = cmdWrData[W-1:0];
        ota_pkg::OTA_CMD_MASK3: mask3D = cmdWrData[W-1:0];
        default: ; // status and unmapped writes are dropped
      endcase
    end
    alarmND[0] = ~|(statFirst & ~{remoteTwoFirstOutBlock,
                                  remoteOneFirstOutBlock,
                                  localEventBlock});
    alarmND[1] = ~|(statSecond & ~mask2Q);
    alarmND[2] = ~|(statThird & ~mask3Q);
  end

  // read mux: registered byte, unmapped commands read zero
  always_comb begin
    rdDataD = rdDataQ;
    if (cmdRdEn) begin
      unique case (cmdAddr)
        ota_pkg::OTA_CMD_COMMON: rdDataD = commonStatus;
        ota_pkg::OTA_CMD_STAT1:  rdDataD = ota_pad(statFirst);
        ota_pkg::OTA_CMD_STAT2:  rdDataD = ota_pad(statSecond);
        ota_pkg::OTA_CMD_STAT3:  rdDataD = ota_pad(statThird);
        ota_pkg::OTA_CMD_MASK1:  rdDataD = ota_pad(mask1Q);
        ota_pkg::OTA_CMD_MASK2:  rdDataD = ota_pad(mask2Q);
        ota_pkg::OTA_CMD_MASK3:  rdDataD = ota_pad(mask3Q);
        default:                 rdDataD = 8'h00;
      endcase
    end
  end

  // register stage for masks, outputs and read port
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mask1Q   <= ota_pkg::OTA_MASK1_RST;
      mask2Q   <= ota_pkg::OTA_MASK2_RST;
      mask3Q   <= ota_pkg::OTA_MASK3_RST;
      alarmNQ  <= 3'h7;
      rdDataQ  <= 8'h00;
      rdValidQ <= 1'b0;
      rdAddrQ  <= 8'h00;
    end else begin
      mask1Q   <= mask1D;
      mask2Q   <= mask2D;
      mask3Q   <= mask3D;
      alarmNQ  <= alarmND;
      rdDataQ  <= rdDataD;
      rdValidQ <= cmdRdEn;
      rdAddrQ  <= cmdRdEn ? cmdAddr : rdAddrQ;
    end
  end

  assign overtempOutFirstN  = alarmNQ[0];
  assign overtempOutSecondN = alarmNQ[1];
  assign overtempOutThirdN  = alarmNQ[2];
  assign cmdRdData          = rdDataQ;
  assign cmdRdValid         = rdValidQ;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // alarm outputs against status and masks
  first_out_active_a: assert property (
    |(statFirst & ~mask1Q) |=> !overtempOutFirstN)
    else $error("first output not active on unmasked status");

  first_out_release_a: assert property (
    (statFirst == 3'h0) |=> overtempOutFirstN)
    else $error("first output not released on empty status");

  second_out_follow_a: assert property (
    ##1 (overtempOutSecondN == ~|($past(statSecond) & $past(mask2Q) ^
                                   $past(statSecond))))
    else $error("second output disagrees with unmasked status");

  third_out_active_a: assert property (
    |(statThird & ~mask3Q) |=> !overtempOutThirdN)
    else $error("third output not active on unmasked status");

  third_mask_block_a: assert property (
    (statThird != 3'h0 && (statThird & ~mask3Q) == 3'h0)
      |=> overtempOutThirdN)
    else $error("third mask failed to block its events");

  mask_all_block_a: assert property (
    (mask1Q == 3'h7) [*2] |-> overtempOutFirstN)
    else $error("fully masked first output went active");

  // comparator flags against readings
  remote_two_first_a: assert property (
    ota_pkg::ota_at_limit(remoteTwoTemp, remoteTwoLimitFirst)
      |=> statFirst[ota_pkg::OTA_BIT_REM2])
    else $error("remote two first-level flag not set");

  remote_one_clear_a: assert property (
    ota_pkg::ota_below_band(remoteOneTemp, remoteOneLimitFirst, commonHyst)
      |=> !statFirst[ota_pkg::OTA_BIT_REM1])
    else $error("remote one first-level flag not cleared");

  local_all_set_a: assert property (
    ota_pkg::ota_at_limit(localTemp, localLimit)
      |=> statFirst[0] && statSecond[0] && statThird[0])
    else $error("local flag missing in a status register");

  remote_two_shared_a: assert property (
    ota_pkg::ota_below_band(remoteTwoTemp, remoteTwoLimitSecond,
                            commonHyst)
      |=> !statSecond[2] && !statThird[2])
    else $error("remote two second-level flag not cleared in both");

  remote_one_second_a: assert property (
    ota_pkg::ota_at_limit(remoteOneTemp, remoteOneLimitSecond)
      |=> statSecond[1] && statThird[1])
    else $error("remote one second-level flag not set in both");

  // register file behaviour
  status_upper_zero_a: assert property (
    cmdRdValid && rdAddrQ >= ota_pkg::OTA_CMD_STAT1 &&
    rdAddrQ <= ota_pkg::OTA_CMD_STAT3 |-> cmdRdData[7:3] == 5'h00)
    else $error("status register upper bits not zero");

  property mask1_write_p;
    logic [2:0] d;
    (cmdWrEn && cmdAddr == ota_pkg::OTA_CMD_MASK1, d = cmdWrData[2:0])
      |=> mask1Q == d;
  endproperty
  mask1_write_a: assert property (mask1_write_p)
    else $error("first mask write not stored");

  summary_read_a: assert property (
    cmdRdValid && rdAddrQ == ota_pkg::OTA_CMD_COMMON
      |-> cmdRdData[3:1] == {|$past(statThird), |$past(statSecond),
                             |$past(statFirst)})
    else $error("common status summary wrong");

  first_out_c:  cover property (overtempOutFirstN ##1 !overtempOutFirstN);
  mask_wr_c:    cover property (cmdWrEn && cmdAddr == ota_pkg::OTA_CMD_MASK3);
  summary_rd_c: cover property (cmdRdValid && cmdRdData[3]);
  release_c:    cover property (!overtempOutThirdN ##1 overtempOutThirdN);

endmodule // ota_alarm_status_mask

// file: tb/ota_host_model.sv
// command-port host model issuing single-byte reads and writes
`timescale 1ns/1ps
module ota_host_model (
  input  wire logic       core_clk,
  output logic      [7:0] cmdAddr,
  output logic            cmdWrEn,
  output logic      [7:0] cmdWrData,
  output logic            cmdRdEn,
  input  wire logic [7:0] cmdRdData,
  input  wire logic       cmdRdValid
);
  // idle values at time zero
  initial begin
    cmdAddr   = 8'h00;
    cmdWrEn   = 1'b0;
    cmdWrData = 8'h00;
    cmdRdEn   = 1'b0;
  end

  // released lines show the inverse of their last value
  task automatic release_bus();
    cmdAddr   <= ~cmdAddr;
    cmdWrData <= ~cmdWrData;
  endtask

  // one-cycle write strobe, taken at the next edge
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    cmdAddr   <= addr;
    cmdWrData <= data;
    cmdWrEn   <= 1'b1;
    @(posedge core_clk);
    cmdWrEn <= 1'b0;
    release_bus();
  endtask

  // one-cycle read strobe, data taken at the edge that sees valid
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data,
                           output logic ok);
    ok   = 1'b0;
    data = 8'h00;
    @(posedge core_clk);
    cmdAddr <= addr;
    cmdRdEn <= 1'b1;
    @(posedge core_clk);
    cmdRdEn <= 1'b0;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge core_clk);
      if (cmdRdValid === 1'b1) begin
        data = cmdRdData;
        ok   = 1'b1;
      end
    end
    release_bus();
  endtask
endmodule // ota_host_model

// file: tb/ota_alarm_status_mask_tb_top.sv
// self-checking bench for the over-temperature alarm block
`timescale 1ns/1ps
module ota_alarm_status_mask_tb_top;
  logic       core_clk;
  logic       rstn;
  logic [7:0] localTemp, remoteOneTemp, remoteTwoTemp;
  logic [7:0] localLimit, commonHyst;
  logic [7:0] remoteOneLimitFirst, remoteTwoLimitFirst;
  logic [7:0] remoteOneLimitSecond, remoteTwoLimitSecond;
  logic [7:0] cmdAddr, cmdWrData, cmdRdData;
  logic       cmdWrEn, cmdRdEn, cmdRdValid;
  logic       overtempOutFirstN, overtempOutSecondN, overtempOutThirdN;
  int         failCount = 0;
  int         checksDone = 0;

  ota_host_model i_host (.core_clk(core_clk), .cmdAddr(cmdAddr),
    .cmdWrEn(cmdWrEn), .cmdWrData(cmdWrData), .cmdRdEn(cmdRdEn),
    .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid));

  ota_alarm_status_mask i_dut (.core_clk(core_clk), .rstn(rstn),
    .localTemp(localTemp), .remoteOneTemp(remoteOneTemp),
    .remoteTwoTemp(remoteTwoTemp), .localLimit(localLimit),
    .remoteOneLimitFirst(remoteOneLimitFirst),
    .remoteTwoLimitFirst(remoteTwoLimitFirst),
    .remoteOneLimitSecond(remoteOneLimitSecond),
    .remoteTwoLimitSecond(remoteTwoLimitSecond),
    .commonHyst(commonHyst), .cmdAddr(cmdAddr), .cmdWrEn(cmdWrEn),
    .cmdWrData(cmdWrData), .cmdRdEn(cmdRdEn), .cmdRdData(cmdRdData),
    .cmdRdValid(cmdRdValid), .overtempOutFirstN(overtempOutFirstN),
    .overtempOutSecondN(overtempOutSecondN),
    .overtempOutThirdN(overtempOutThirdN));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // verdict and end of run
  task automatic completeRun();
    if (failCount == 0 && checksDone > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // byte comparison
  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read a register and compare it
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    logic       ok;
    i_host.read_byte(addr, got, ok);
    if (!ok) begin
      failCount++;
      completeRun();
    end else begin
      chk_byte($sformatf("reg %h", addr), exp, got);
      // valid stands one cycle, read data holds until the next read
      @(negedge core_clk);
      chk_byte("read valid", 8'h00, {7'h00, cmdRdValid});
      chk_byte("read hold", got, cmdRdData);
    end
  endtask

  // alarm pins as {third, second, first}, active low
  task automatic chk_pins(input logic [2:0] exp);
    @(negedge core_clk); // look at the pins away from the launching edge
    chk_byte("alarm pins", {5'h00, exp}, {5'h00, overtempOutThirdN,
             overtempOutSecondN, overtempOutFirstN});
  endtask

  // new readings, then let flag and pin settle
  task automatic set_temps(input logic [7:0] l, input logic [7:0] r1,
                           input logic [7:0] r2);
    @(posedge core_clk);
    localTemp     <= l;
    remoteOneTemp <= r1;
    remoteTwoTemp <= r2;
    repeat (3) @(posedge core_clk);
  endtask

  // register write, then let the pins follow
  task automatic wr_set(input logic [7:0] addr, input logic [7:0] data);
    i_host.write_byte(addr, data);
    repeat (3) @(posedge core_clk);
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    failCount++;
    completeRun();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    localTemp = 8'h20;
    remoteOneTemp = 8'h20;
    remoteTwoTemp = 8'h20;
    localLimit = 8'h50;
    remoteOneLimitFirst = 8'h60;
    remoteTwoLimitFirst = 8'h70;
    remoteOneLimitSecond = 8'h80;
    remoteTwoLimitSecond = 8'h90;
    commonHyst = 8'h05;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    chk_pins(3'h7);
    rd_chk(ota_pkg::OTA_CMD_MASK1, 8'h01);
    rd_chk(ota_pkg::OTA_CMD_MASK3, 8'h07);
    rd_chk(ota_pkg::OTA_CMD_MASK2, 8'h00);
    rd_chk(8'h30, 8'h00);
    // local exactly at its limit
    set_temps(8'h50, 8'h20, 8'h20);
    for (int i = 0; i < 3; i++)
      rd_chk(ota_pkg::OTA_CMD_STAT1 + 8'(i), 8'h01);
    chk_pins(3'h5);
    rd_chk(ota_pkg::OTA_CMD_COMMON, 8'h0E);
    set_temps(8'h4B, 8'h20, 8'h20);
    rd_chk(ota_pkg::OTA_CMD_STAT1, 8'h01);
    set_temps(8'h4A, 8'h20, 8'h20);
    rd_chk(ota_pkg::OTA_CMD_STAT2, 8'h00);
    chk_pins(3'h7);
    // remote two at first-level limit
    set_temps(8'h20, 8'h20, 8'h70);
    rd_chk(ota_pkg::OTA_CMD_STAT1, 8'h04);
    rd_chk(ota_pkg::OTA_CMD_STAT2, 8'h00);
    chk_pins(3'h6);
    rd_chk(ota_pkg::OTA_CMD_COMMON, 8'h02);
    wr_set(ota_pkg::OTA_CMD_MASK1, 8'hFF);
    rd_chk(ota_pkg::OTA_CMD_MASK1, 8'h07);
    chk_pins(3'h7);
    wr_set(ota_pkg::OTA_CMD_MASK1, 8'h00);
    set_temps(8'h20, 8'h20, 8'h6A);
    rd_chk(ota_pkg::OTA_CMD_STAT1, 8'h00);
    chk_pins(3'h7);
    // remote one at second-level limit
    set_temps(8'h20, 8'h80, 8'h20);
    rd_chk(ota_pkg::OTA_CMD_STAT1, 8'h02);
    rd_chk(ota_pkg::OTA_CMD_STAT2, 8'h02);
    rd_chk(ota_pkg::OTA_CMD_STAT3, 8'h02);
    chk_pins(3'h4);
    // second mask blocks remote one from the second output
    wr_set(ota_pkg::OTA_CMD_MASK2, 8'h02);
    rd_chk(ota_pkg::OTA_CMD_MASK2, 8'h02);
    chk_pins(3'h6);
    wr_set(ota_pkg::OTA_CMD_MASK2, 8'h00);
    wr_set(ota_pkg::OTA_CMD_MASK3, 8'h00);
    set_temps(8'h20, 8'h80, 8'h90);
    chk_pins(3'h0);
    rd_chk(ota_pkg::OTA_CMD_STAT2, 8'h06);
    rd_chk(ota_pkg::OTA_CMD_STAT3, 8'h06);
    // status writes are ignored
    for (int i = 0; i < 3; i++)
      i_host.write_byte(ota_pkg::OTA_CMD_STAT1 + 8'(i), 8'hFF);
    for (int i = 0; i < 3; i++)
      rd_chk(ota_pkg::OTA_CMD_STAT1 + 8'(i), 8'h06);
    set_temps(8'h20, 8'h20, 8'h20);
    chk_pins(3'h7);
    // mid-run reset brings the masks back to their power-up values
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    chk_pins(3'h7);
    rd_chk(ota_pkg::OTA_CMD_MASK1, 8'h01);
    rd_chk(ota_pkg::OTA_CMD_MASK3, 8'h07);
    completeRun();
  end
endmodule // ota_alarm_status_mask_tb_top
